// ---- core/asmr_defines.vh ----
// Constants for the analog scan and motor relay block
`ifndef ASMR_DEFINES_VH
`define ASMR_DEFINES_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASMR_REG_CTRL 12'h000
`define ASMR_REG_STATUS 12'h004
`define ASMR_REG_MODE 12'h008
`define ASMR_REG_SETPT 12'h00c
`define ASMR_REG_MOTOUT 12'h010
`define ASMR_REG_RELAY 12'h014
`define ASMR_REG_TABLE 12'h100
`define ASMR_REG_RESULT 12'h200
`define ASMR_REG_SPEED 12'h018
// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define ASMR_END_BIT 7
`define ASMR_GAIN_HI 6
`define ASMR_GAIN_LO 5
`define ASMR_CHAN_HI 4
`define ASMR_CTL_SEL 0
`define ASMR_CTL_ENLO 1
`define ASMR_CTL_ENHI 2
`define ASMR_DIR_UP 2'b10
`define ASMR_DIR_DOWN 2'b01
`define ASMR_DIR_STOP 2'b00
`define ASMR_MAX_FILT 3'h4
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ASMR_CLK_NS 40
`define ASMR_TIMEOUT_US 100
`define ASMR_TIMEOUT_CYC ((`ASMR_TIMEOUT_US * 1000) / `ASMR_CLK_NS)
`endif

// ---- core/asmr_smoother.v ----
// First order smoother stage for one sample
`timescale 1ns/10ps
`default_nettype none
module asmr_smoother #(
  parameter W = 16
) (
  input wire [W-1:0] sample,
  input wire [W-1:0] prev,
  input wire [2:0] shift,
  output reg [W-1:0] result
);
  // ----------------------------------------------------------------
  // y = prev + (x - prev) / 2^n, unity gain for constant input
  // ----------------------------------------------------------------
  reg signed [W+1:0] diff;
  reg signed [W+1:0] step;
  reg signed [W+1:0] sum;
  always @* begin
    diff = $signed({2'b00, sample}) - $signed({2'b00, prev});
    step = diff >>> shift;
    sum = $signed({2'b00, prev}) + step;
    if (shift == 3'h0) begin
      result = sample;
    end else begin
      result = sum[W-1:0];
    end
  end
endmodule // asmr_smoother
`default_nettype wire

// ---- core/asmr_top.v ----
// Channel scan sequencer and motor direction relay logic with APB registers
`timescale 1ns/10ps
`default_nettype none
`include "asmr_defines.vh"
module asmr_top #(
  parameter TABLE_LEN = 32,
  parameter AW = 5,
  parameter DW = 16,
  parameter TIMEOUT = `ASMR_TIMEOUT_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire second_tick,
  output reg [4:0] adc_channel,
  output reg [1:0] adc_gain,
  output reg adc_mux_load,
  output reg adc_start,
  input wire adc_ready,
  input wire adc_data_valid,
  input wire [DW-1:0] adc_data,
  input wire [7:0] relay_status,
  output reg [7:0] relay_out,
  output reg [2:0] relay_ctrl,
  output reg [15:0] dac_speed0,
  output reg [15:0] dac_speed1,
  output reg [15:0] dac_speed2,
  output reg [15:0] dac_speed3
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_FETCH = 8'h02;
  localparam [7:0] S_PROG = 8'h04;
  localparam [7:0] S_FILT = 8'h08;
  localparam [7:0] S_RDY = 8'h10;
  localparam [7:0] S_DATA = 8'h20;
  localparam [7:0] S_LAST = 8'h40;
  localparam [7:0] S_TRIG = 8'h80;
  localparam [31:0] TMO = TIMEOUT;

  // ----------------------------------------------------------------
  // Storage and control
  // ----------------------------------------------------------------
  reg [7:0] table_mem [0:2*TABLE_LEN-1];
  reg [DW-1:0] result_mem [0:TABLE_LEN-1];
  reg [7:0] state;
  reg [AW-1:0] idx;
  reg [DW-1:0] sample;
  reg [31:0] wait_cnt;
  reg scan_err;
  reg scan_busy;
  reg init_req;
  reg [2:0] mode;
  reg [2:0] ctl_bits;
  reg [63:0] setpoints;
  reg [63:0] motor_out;
  reg [63:0] speed_in;
  reg [7:0] status_byte;
  reg [7:0] setpt_byte;
  wire [DW-1:0] smooth;
  wire [7:0] next_desc;
  wire [7:0] cur_filt;
  wire [AW-1:0] idx_next;
  wire wr;
  wire rd;
  wire in_charge;
  integer i;
  integer j;
  integer n;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign idx_next = idx + {{(AW-1){1'b0}}, 1'b1};
  assign next_desc = table_mem[{idx_next, 1'b0}];
  assign cur_filt = table_mem[{idx, 1'b1}];
  assign in_charge = (mode != 3'h0) && ctl_bits[`ASMR_CTL_SEL] &&
    !ctl_bits[`ASMR_CTL_ENLO] && ctl_bits[`ASMR_CTL_ENHI];

  // ----------------------------------------------------------------
  // Filter stage
  // ----------------------------------------------------------------
  asmr_smoother #(.W(DW)) i_asmr_smoother (
    .sample(sample),
    .prev(result_mem[idx]),
    .shift((cur_filt > {5'h00, `ASMR_MAX_FILT}) ? `ASMR_MAX_FILT : cur_filt[2:0]),
    .result(smooth)
  );

  // ----------------------------------------------------------------
  // Descriptor table
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (wr && paddr[11:8] == 4'h1) begin
      table_mem[paddr[AW+2:2]] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 3'h0;
      ctl_bits <= 3'h2;
      setpoints <= 64'h0;
      motor_out <= 64'h0;
      init_req <= 1'b0;
    end else begin
      init_req <= 1'b0;
      if (wr) begin
        case (paddr)
          `ASMR_REG_CTRL: begin
            ctl_bits <= pwdata[2:0];
            init_req <= pwdata[8];
          end
          `ASMR_REG_MODE: mode <= pwdata[2:0];
          `ASMR_REG_SETPT: setpoints[{pwdata[17:16], 4'h0} +: 16] <= pwdata[15:0];
          `ASMR_REG_MOTOUT: motor_out[{pwdata[17:16], 4'h0} +: 16] <= pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // APB reads
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd) begin
      if (paddr[11:8] == 4'h1) begin
        prdata <= {24'h0, table_mem[paddr[AW+2:2]]};
      end else if (paddr[11:8] == 4'h2) begin
        prdata <= {{(32-DW){1'b0}}, result_mem[paddr[AW+1:2]]};
      end else begin
        case (paddr)
          `ASMR_REG_CTRL: prdata <= {29'h0, ctl_bits};
          `ASMR_REG_STATUS: prdata <= {15'h0, in_charge, setpt_byte, status_byte};
          `ASMR_REG_MODE: prdata <= {29'h0, mode};
          `ASMR_REG_RELAY: prdata <= {22'h0, scan_err, scan_busy, relay_out};
          `ASMR_REG_SPEED: prdata <= {16'h0, speed_in[15:0]};
          `ASMR_REG_SPEED + 12'h004: prdata <= {16'h0, speed_in[31:16]};
          `ASMR_REG_SPEED + 12'h008: prdata <= {16'h0, speed_in[47:32]};
          `ASMR_REG_SPEED + 12'h00c: prdata <= {16'h0, speed_in[63:48]};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel scan sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      idx <= {AW{1'b0}};
      sample <= {DW{1'b0}};
      wait_cnt <= 32'h0;
      scan_err <= 1'b0;
      scan_busy <= 1'b0;
      adc_channel <= 5'h00;
      adc_gain <= 2'b00;
      adc_mux_load <= 1'b0;
      adc_start <= 1'b0;
      for (n = 0; n < TABLE_LEN; n = n + 1) begin
        result_mem[n] <= {DW{1'b0}};
      end
    end else begin
      adc_mux_load <= 1'b0;
      adc_start <= 1'b0;
      case (state)
        S_IDLE: begin
          idx <= {AW{1'b0}};
          wait_cnt <= 32'h0;
          if (second_tick) begin
            scan_busy <= 1'b1;
            scan_err <= 1'b0;
            state <= table_mem[0][`ASMR_END_BIT] ? S_IDLE : S_FETCH;
            scan_busy <= ~table_mem[0][`ASMR_END_BIT];
          end else if (init_req) begin
            state <= S_LAST;
          end
        end
        S_FETCH: begin
          sample <= adc_data;
          state <= S_PROG;
        end
        S_PROG: begin
          if (!next_desc[`ASMR_END_BIT] && idx_next != {AW{1'b0}}) begin
            adc_channel <= next_desc[`ASMR_CHAN_HI:0];
            adc_gain <= next_desc[`ASMR_GAIN_HI:`ASMR_GAIN_LO];
            adc_mux_load <= 1'b1;
          end
          state <= S_FILT;
        end
        S_FILT: begin
          result_mem[idx] <= smooth;
          wait_cnt <= 32'h0;
          if (next_desc[`ASMR_END_BIT] || idx_next == {AW{1'b0}}) begin
            state <= S_LAST;
          end else begin
            idx <= idx_next;
            state <= S_RDY;
          end
        end
        S_RDY: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (adc_ready) begin
            adc_start <= 1'b1;
            wait_cnt <= 32'h0;
            state <= S_DATA;
          end else if (wait_cnt >= TMO - 32'h1) begin
            scan_err <= 1'b1;
            scan_busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_DATA: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (adc_data_valid && !adc_start) begin
            sample <= adc_data;
            state <= S_PROG;
          end else if (wait_cnt >= TMO - 32'h1) begin
            scan_err <= 1'b1;
            scan_busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_LAST: begin
          adc_channel <= table_mem[0][`ASMR_CHAN_HI:0];
          adc_gain <= table_mem[0][`ASMR_GAIN_HI:`ASMR_GAIN_LO];
          adc_mux_load <= 1'b1;
          wait_cnt <= 32'h0;
          state <= S_TRIG;
        end
        S_TRIG: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (adc_ready) begin
            adc_start <= 1'b1;
            scan_busy <= 1'b0;
            state <= S_IDLE;
          end else if (wait_cnt >= TMO - 32'h1) begin
            scan_err <= 1'b1;
            scan_busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Motor direction relay logic
  // ----------------------------------------------------------------
  reg [7:0] next_status;
  reg [7:0] next_setpt;
  reg [7:0] next_out;
  reg [15:0] sp;
  always @* begin
    next_status = 8'h00;
    next_setpt = 8'h00;
    sp = 16'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (relay_status[2*i +: 2] == `ASMR_DIR_UP || relay_status[2*i +: 2] == `ASMR_DIR_DOWN) begin
        next_status[2*i +: 2] = relay_status[2*i +: 2];
      end
      sp = setpoints[16*i +: 16];
      if (sp != 16'h0) begin
        next_setpt[2*i +: 2] = sp[15] ? `ASMR_DIR_DOWN : `ASMR_DIR_UP;
      end
    end
    next_out = next_status | next_setpt;
    for (i = 0; i < 4; i = i + 1) begin
      if (setpoints[16*i +: 16] == 16'h0) begin
        next_out[2*i +: 2] = 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Relay port
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_out <= 8'h00;
      relay_ctrl <= 3'h2;
    end else begin
      relay_ctrl <= {ctl_bits[2:1], ctl_bits[0] & (mode != 3'h0)};
      if (!in_charge) begin
        relay_out <= 8'h00;
      end else if (second_tick) begin
        relay_out <= next_out;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_byte <= 8'h00;
      setpt_byte <= 8'h00;
      speed_in <= 64'h0;
      dac_speed0 <= 16'h0;
      dac_speed1 <= 16'h0;
      dac_speed2 <= 16'h0;
      dac_speed3 <= 16'h0;
    end else begin
      if (second_tick) begin
        status_byte <= next_status;
        setpt_byte <= next_setpt;
        for (j = 0; j < 4; j = j + 1) begin
          speed_in[16*j +: 16] <= (next_status[2*j +: 2] == 2'b00) ? 16'h0 :
            {{(16-DW){1'b0}}, result_mem[j]};
        end
        dac_speed0 <= motor_out[15] ? -motor_out[15:0] : motor_out[15:0];
        dac_speed1 <= motor_out[31] ? -motor_out[31:16] : motor_out[31:16];
        dac_speed2 <= motor_out[47] ? -motor_out[47:32] : motor_out[47:32];
        dac_speed3 <= motor_out[63] ? -motor_out[63:48] : motor_out[63:48];
      end
    end
  end
endmodule // asmr_top
`default_nettype wire

// ---- verification/asmr_adc_model.sv ----
// Behavioural model of the converter board seen by the scan sequencer
`timescale 1ns/10ps
`default_nettype none
module asmr_adc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] adc_channel,
  input wire logic [1:0] adc_gain,
  input wire logic adc_mux_load,
  input wire logic adc_start,
  input wire logic mute,
  output logic adc_ready,
  output logic adc_data_valid,
  output logic [15:0] adc_data
);
  // ----------------------------------------
  // Conversion engine
  // ----------------------------------------
  logic [1:0] gain_log [0:31];
  logic [2:0] cnt;
  logic [15:0] val;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_ready <= 1'b1;
      adc_data_valid <= 1'b0;
      cnt <= 3'h0;
      val <= 16'h0000;
    end else begin
      if (adc_mux_load)
        gain_log[adc_channel] <= adc_gain;
      if (adc_start) begin
        adc_ready <= 1'b0;
        adc_data_valid <= 1'b0;
        cnt <= mute ? 3'h0 : 3'h3;
        val <= {3'h0, adc_channel + 5'h01, 8'h00};
      end else if (cnt == 3'h1) begin
        adc_ready <= 1'b1;
        adc_data_valid <= 1'b1;
        cnt <= 3'h0;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
  // Result holds until the next start, garbage while converting
  assign adc_data = adc_data_valid ? val : ~val;
endmodule // asmr_adc_model
`default_nettype wire

// ---- verification/asmr_top_asserts.sv ----
// Concurrent checks on the ports of the scan and relay block
`timescale 1ns/10ps
`default_nettype none
module asmr_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_mux_load,
  input wire logic adc_start,
  input wire logic adc_ready,
  input wire logic [7:0] relay_out,
  input wire logic [2:0] relay_ctrl
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (pready) else $error("pready low");
  slverr_low_a: assert property (!pslverr) else $error("pslverr high");
  relay_gate_a: assert property (relay_out != 8'h00 |-> relay_ctrl == 3'b101)
    else $error("relay output while not enabled");
  start_ready_a: assert property (adc_start |-> $past(adc_ready))
    else $error("start without ready");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  mux_pulse_a: assert property (adc_mux_load |=> !adc_mux_load)
    else $error("mux load longer than one cycle");
  reset_ctrl_a: assert property ($rose(presetn) |-> relay_ctrl == 3'b010)
    else $error("relay control not safe after reset");
  ctrl_cause_a: assert property ($changed(relay_ctrl) |->
    $past(psel && penable && pwrite && (paddr == 12'h000 || paddr == 12'h008), 2))
    else $error("relay control changed without write");
endmodule // asmr_top_asserts
bind asmr_top asmr_top_asserts i_asmr_top_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .adc_mux_load(adc_mux_load), .adc_start(adc_start),
  .adc_ready(adc_ready), .relay_out(relay_out), .relay_ctrl(relay_ctrl));
`default_nettype wire

// ---- verification/asmr_top_tb_top.sv ----
// Self-checking testbench for the scan and relay block
`timescale 1ns/10ps
`default_nettype none
`include "asmr_defines.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module asmr_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic second_tick = 0, mute = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  logic [7:0] relay_status = 0;
  logic [7:0] tbl [0:4] = '{8'h23, 8'h00, 8'h65, 8'h01, 8'hff};
  wire [31:0] prdata;
  wire pready, pslverr, adc_mux_load, adc_start, adc_ready, adc_data_valid;
  wire [4:0] adc_channel;
  wire [1:0] adc_gain;
  wire [15:0] adc_data, dac_speed0, dac_speed1, dac_speed2, dac_speed3;
  wire [7:0] relay_out;
  wire [2:0] relay_ctrl;
  int mismatches = 0, compares = 0, k;
  always #20 pclk = ~pclk;
  asmr_top #(.TIMEOUT(20)) i_asmr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .second_tick(second_tick),
    .adc_channel(adc_channel), .adc_gain(adc_gain), .adc_mux_load(adc_mux_load),
    .adc_start(adc_start), .adc_ready(adc_ready), .adc_data_valid(adc_data_valid),
    .adc_data(adc_data), .relay_status(relay_status), .relay_out(relay_out),
    .relay_ctrl(relay_ctrl), .dac_speed0(dac_speed0), .dac_speed1(dac_speed1),
    .dac_speed2(dac_speed2), .dac_speed3(dac_speed3));
  asmr_adc_model i_asmr_adc_model (.pclk(pclk), .presetn(presetn),
    .adc_channel(adc_channel), .adc_gain(adc_gain), .adc_mux_load(adc_mux_load),
    .adc_start(adc_start), .mute(mute), .adc_ready(adc_ready),
    .adc_data_valid(adc_data_valid), .adc_data(adc_data));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk_rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask
  task pass();
    @(posedge pclk) second_tick <= 1'b1;
    @(posedge pclk) second_tick <= 1'b0;
    do apb(1'b0, `ASMR_REG_RELAY, 32'h0); while (r[8] !== 1'b0);
  endtask
  task summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(relay_ctrl, 3'b010)
    `CHK(relay_out, 8'h00)
    chk_rd(12'h0f0, 32'h0);
    for (k = 0; k < 5; k++) apb(1'b1, 12'(12'h100 + 4 * k), {24'h0, tbl[k]});
    chk_rd(12'h108, 32'h65);
    apb(1'b1, `ASMR_REG_MODE, 32'h1);
    apb(1'b1, `ASMR_REG_CTRL, 32'h105);
    repeat (2) @(posedge pclk);
    `CHK(relay_ctrl, 3'b101)
    apb(1'b1, `ASMR_REG_SETPT, 32'h0_0100);
    apb(1'b1, `ASMR_REG_SETPT, 32'h1_ff00);
    apb(1'b1, `ASMR_REG_SETPT, 32'h2_0000);
    apb(1'b1, `ASMR_REG_SETPT, 32'h3_0005);
    apb(1'b1, `ASMR_REG_MOTOUT, 32'h0_0100);
    apb(1'b1, `ASMR_REG_MOTOUT, 32'h1_fed4);
    apb(1'b1, `ASMR_REG_MOTOUT, 32'h3_ffff);
    relay_status <= 8'h25;
    pass();
    `CHK(relay_out, 8'h87)
    chk_rd(`ASMR_REG_STATUS, 32'h1_8625);
    chk_rd(12'h200, 32'h400);
    chk_rd(12'h204, 32'h300);
    `CHK(dac_speed1, 16'h012c)
    `CHK(dac_speed0, 16'h0100)
    `CHK(dac_speed2, 16'h0000)
    `CHK(dac_speed3, 16'h0001)
    `CHK(adc_channel, 5'h03)
    `CHK(adc_gain, 2'b01)
    `CHK(i_asmr_adc_model.gain_log[3], 2'b01)
    `CHK(i_asmr_adc_model.gain_log[5], 2'b11)
    relay_status <= 8'h24;
    pass();
    `CHK(relay_out, 8'h86)
    chk_rd(12'h204, 32'h480);
    chk_rd(12'h018, 32'h0);
    chk_rd(12'h01c, 32'h300);
    apb(1'b1, `ASMR_REG_CTRL, 32'h7);
    pass();
    `CHK(relay_out, 8'h00)
    mute <= 1'b1;
    pass();
    `CHK(r[9], 1'b1)
    apb(1'b1, `ASMR_REG_MODE, 32'h0);
    apb(1'b1, `ASMR_REG_CTRL, 32'h5);
    apb(1'b0, `ASMR_REG_STATUS, 32'h0);
    `CHK(r[16], 1'b0)
    `CHK(relay_ctrl, 3'b100)
    summarize();
  end
endmodule // asmr_top_tb_top
`default_nettype wire
